// ==== include/host_port_pkg.sv ====
// Shared constants, pin layout and helpers for the parallel host port.
package host_port_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int WR8_DONE_NS   = 200;
  localparam int WR16_DONE_NS  = 280;
  // Longest times round down on the device side, least times round up on the host side.
  localparam int WR8_DONE_CYC  = WR8_DONE_NS / CLK_PERIOD_NS;
  localparam int WR16_DONE_CYC = WR16_DONE_NS / CLK_PERIOD_NS;
  localparam int WR8_HOLD_CYC  = (WR8_DONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR16_HOLD_CYC = (WR16_DONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Pin to synchroniser to state register to wait flop.
  localparam int WAIT_LAT_CYC  = 4;
  localparam logic [3:0] WR8_LOAD  = 4'(WR8_DONE_CYC - WAIT_LAT_CYC);
  localparam logic [3:0] WR16_LOAD = 4'(WR16_DONE_CYC - WAIT_LAT_CYC);
  localparam logic [3:0] WR8_HOLD  = 4'(WR8_HOLD_CYC - 1);
  localparam logic [3:0] WR16_HOLD = 4'(WR16_HOLD_CYC - 1);
  localparam logic [3:0] RD_HOLD   = 4'h7;
  localparam logic [3:0] LATCH_LOAD = 4'h3;
  localparam logic [3:0] LATCH_DROP = 4'h1;
  localparam logic [3:0] GAP_LOAD   = 4'h1;

  // ----------------------------------------
  // Pin vector layout
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int P_CS = 0;
  localparam int P_RD = 1;
  localparam int P_WR = 2;
  localparam int P_LL = 3;
  localparam int P_LH = 4;
  localparam int P_BE = 5;
  localparam int P_AD = 7;
  localparam int PIN_W = P_AD + DATA_W;
  localparam logic [1:0] BE_WIDE = 2'h3;

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [3:0] {
    D_IDLE  = 4'b0001,
    D_WRITE = 4'b0010,
    D_HOLD  = 4'b0100,
    D_READ  = 4'b1000
  } dev_st_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LO   = 4'b0010,
    H_HI   = 4'b0100,
    H_STRB = 4'b1000
  } host_st_t;

  // Maps a pin level to its active meaning, or an active meaning to a pin level.
  function automatic logic pin_act(input logic lvl, input logic pol);
    return ~(lvl ^ pol);
  endfunction

endpackage

// ==== include/host_port_if.sv ====
// Pins of the parallel host port between host and device.
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
  logic        cs;
  logic        rd_dir;
  logic        wr_en;
  logic        addr_latch_low;
  logic        addr_latch_high;
  logic [1:0]  be;
  logic [15:0] host_ad;
  logic        host_ad_oe;
  logic [15:0] dev_ad;
  logic        dev_ad_oe;
  logic        wait_lvl;
  logic        wait_oe;
  logic [15:0] ad;
  logic        wait_pin;

  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  // An undriven bus reads zero; an undriven wait line is pulled high.
  assign ad       = host_ad_oe ? host_ad : (dev_ad_oe ? dev_ad : 16'h0000);
  assign wait_pin = wait_oe ? wait_lvl : 1'b1;

  modport device (
    input  cs, rd_dir, wr_en, addr_latch_low, addr_latch_high, be, ad,
    output dev_ad, dev_ad_oe, wait_lvl, wait_oe
  );
  modport host (
    output cs, rd_dir, wr_en, addr_latch_low, addr_latch_high, be, host_ad, host_ad_oe,
    input  ad, wait_pin
  );
endinterface
`default_nettype wire

// ==== rtl/host_port_device.sv ====
// Device end of the parallel host port: cycle decode, address latches, wait handshake.
//
// Functional notes
// [RULE1] Direct writes: wait driven only under select.
// [RULE2] Host holds write strobe until wait inactive.
// [RULE3] Without wait, host holds worst-case write time.
// [RULE4] Write done within 200/280 ns.
// [RULE5] Write strobe under select starts a write.
// [RULE6] Transfer strobe with write direction starts write.
// [RULE7] Select never changes while a strobe active.
// [RULE8] Read strobe or read direction starts read.
// [RULE9] Legacy mode holds wait inactive when enabled.
// [RULE10] Each control line polarity is selectable; here the address latch lines stay fixed active-high.
// [RULE11] Any back-to-back cycle order is accepted.
// [RULE12] Two address phases, either order, select-qualified.
// [RULE13] Address phase captured on latch release.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module host_port_device
  import host_port_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                         mclk,
  input  wire logic                         reset_n,
  input  wire logic                         ce,
  // Port configuration
  input  wire logic                         pol_wait,
  input  wire logic                         pol_cs,
  input  wire logic                         pol_rd_dir,
  input  wire logic                         pol_wr_en,
  input  wire logic                         dir_strobe_mode,
  input  wire logic                         direct_mode,
  input  wire logic                         wait_en,
  // Host pins
  host_port_if.device                       pins,
  // User side
  output logic                              wr_stb,
  output logic                              rd_stb,
  output logic [31:0]                       acc_addr,
  output logic [host_port_pkg::DATA_W-1:0]  wr_data,
  output logic [1:0]                        wr_be,
  input  wire logic [host_port_pkg::DATA_W-1:0] rd_data,
  output logic                              busy
);
  import host_port_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [PIN_W-1:0]  s1;
    logic [PIN_W-1:0]  s2;
    logic [1:0]        arm;
    logic              ll_p;
    logic              lh_p;
    logic [DATA_W-1:0] alo;
    logic [DATA_W-1:0] ahi;
    dev_st_t           st;
    logic [3:0]        cnt;
    logic              wait_act;
    logic              wait_lvl;
    logic              wait_oe;
    logic [DATA_W-1:0] dout;
    logic              dout_oe;
    logic              wr_stb;
    logic              rd_stb;
    logic              rd_pend;
    logic [31:0]       addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        wbe;
    logic              busy;
  } dev_q_t;

  localparam dev_q_t DEV_RST = '{st: D_IDLE, default: '0};

  dev_q_t q_q;
  dev_q_t q_d;

  logic              cs_a;
  logic              rd_a;
  logic              wr_a;
  logic              ll;
  logic              lh;
  logic              strobe_a;
  logic              wr_go;
  logic              rd_go;
  logic              wide;
  logic              commit;
  logic [DATA_W-1:0] ad;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    q_d    = q_q;
    commit = 1'b0;
    // Every pin passes two flops; only the second stage is decoded.
    q_d.s1 = {pins.ad, pins.be, pins.addr_latch_high, pins.addr_latch_low,
              pins.wr_en, pins.rd_dir, pins.cs};
    q_d.s2 = q_q.s1;
    // Zero in the sync stages is an active level under low-true polarity, so select
    // stays masked until both stages hold real pin levels after reset.
    q_d.arm = {q_q.arm[0], 1'b1};
    cs_a = q_q.arm[1] & pin_act(q_q.s2[P_CS], pol_cs);  // [RULE10]
    rd_a = pin_act(q_q.s2[P_RD], pol_rd_dir);   // [RULE10]
    wr_a = pin_act(q_q.s2[P_WR], pol_wr_en);    // [RULE10]
    ll   = q_q.s2[P_LL];
    lh   = q_q.s2[P_LH];
    ad   = q_q.s2[P_AD +: DATA_W];
    wide = (q_q.s2[P_BE +: 2] == BE_WIDE);
    strobe_a = dir_strobe_mode ? wr_a : (wr_a | rd_a);
    wr_go = cs_a & wr_a & (dir_strobe_mode ? ~rd_a : 1'b1);  // [RULE5] [RULE6]
    rd_go = cs_a & (dir_strobe_mode ? (wr_a & rd_a) : (rd_a & ~wr_a));  // [RULE8]
    q_d.ll_p    = ll;
    q_d.lh_p    = lh;
    q_d.wr_stb  = 1'b0;
    q_d.rd_stb  = 1'b0;
    q_d.rd_pend = 1'b0;

    // Either phase may come first; each stands until its latch is pulsed again.
    if (cs_a && q_q.ll_p && !ll) begin
      q_d.alo = ad;  // [RULE12] [RULE13]
    end
    if (cs_a && q_q.lh_p && !lh) begin
      q_d.ahi = ad;  // [RULE12] [RULE13]
    end

    case (q_q.st)
      D_IDLE: begin
        if (wr_go) begin
          q_d.busy = 1'b1;
          if (direct_mode) begin
            q_d.st       = D_WRITE;
            q_d.wait_act = 1'b1;  // [RULE1]
            q_d.cnt      = wide ? WR16_LOAD : WR8_LOAD;  // [RULE4]
          end else begin
            commit   = 1'b1;
            q_d.st   = D_HOLD;
          end
        end else if (rd_go) begin
          q_d.busy    = 1'b1;
          q_d.rd_stb  = 1'b1;
          q_d.rd_pend = 1'b1;
          q_d.addr    = {q_q.ahi, q_q.alo};
          q_d.st      = D_READ;
        end
      end
      D_WRITE: begin
        // The host keeps data and strobe until wait goes inactive, so sample late.
        if (q_q.cnt == 4'h0) begin
          commit       = 1'b1;
          q_d.wait_act = 1'b0;  // [RULE4] [RULE2]
          q_d.st       = D_HOLD;
        end else begin
          q_d.cnt = q_q.cnt - 4'h1;
        end
      end
      D_HOLD: begin
        // Back to idle as soon as the strobe drops, so any cycle may follow.
        if (!strobe_a) begin
          q_d.st   = D_IDLE;  // [RULE5] [RULE6] [RULE11]
          q_d.busy = 1'b0;
        end
      end
      D_READ: begin
        if (q_q.rd_pend) begin
          q_d.dout    = rd_data;
          q_d.dout_oe = 1'b1;
        end else if (!strobe_a) begin
          q_d.dout_oe = 1'b0;  // [RULE8] [RULE11]
          q_d.st      = D_IDLE;
          q_d.busy    = 1'b0;
        end
      end
      default: begin
        q_d.st       = D_IDLE;
        q_d.wait_act = 1'b0;
        q_d.dout_oe  = 1'b0;
        q_d.busy     = 1'b0;
      end
    endcase

    if (commit) begin
      q_d.wr_stb = 1'b1;
      q_d.addr   = {q_q.ahi, q_q.alo};
      q_d.wdata  = ad;
      q_d.wbe    = q_q.s2[P_BE +: 2];
    end

    // The buffer is released with select as well, never left driving a bus it lost.
    q_d.dout_oe  = q_d.dout_oe & cs_a;
    q_d.wait_oe  = wait_en & cs_a;  // [RULE1]
    q_d.wait_lvl = pin_act(direct_mode & q_d.wait_act, pol_wait);  // [RULE9] [RULE10]
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q_q <= DEV_RST;
    end else if (ce) begin
      q_q <= q_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pins.dev_ad    = q_q.dout;
  assign pins.dev_ad_oe = q_q.dout_oe;
  assign pins.wait_lvl  = q_q.wait_lvl;
  assign pins.wait_oe   = q_q.wait_oe;
  assign wr_stb         = q_q.wr_stb;
  assign rd_stb         = q_q.rd_stb;
  assign acc_addr       = q_q.addr;
  assign wr_data        = q_q.wdata;
  assign wr_be          = q_q.wbe;
  assign busy           = q_q.busy;

endmodule // host_port_device
`default_nettype wire

// ==== rtl/host_port_host.sv ====
// Host end of the parallel host port: runs multiplexed-address read and write cycles.
`timescale 1ns/1ps
`default_nettype none
module host_port_host
  import host_port_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                         mclk,
  input  wire logic                         reset_n,
  input  wire logic                         ce,
  // Port configuration
  input  wire logic                         pol_wait,
  input  wire logic                         pol_cs,
  input  wire logic                         pol_rd_dir,
  input  wire logic                         pol_wr_en,
  input  wire logic                         dir_strobe_mode,
  input  wire logic                         direct_mode,
  input  wire logic                         wait_en,
  // Command side
  input  wire logic                         cmd_valid,
  input  wire logic                         cmd_write,
  input  wire logic                         cmd_wide,
  input  wire logic [31:0]                  cmd_addr,
  input  wire logic [host_port_pkg::DATA_W-1:0] cmd_data,
  output logic                              busy,
  output logic                              done,
  output logic [host_port_pkg::DATA_W-1:0]  rsp_data,
  // Pins
  host_port_if.host                         pins
);
  import host_port_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [DATA_W:0]   s1;
    logic [DATA_W:0]   s2;
    host_st_t          st;
    logic [3:0]        cnt;
    logic              gap;
    logic              seen;
    logic              wr;
    logic              wide;
    logic [31:0]       addr;
    logic [DATA_W-1:0] data;
    logic              cs;
    logic              rdd;
    logic              wre;
    logic              ll;
    logic              lh;
    logic [1:0]        be;
    logic [DATA_W-1:0] ad;
    logic              ad_oe;
    logic              busy;
    logic              done;
    logic [DATA_W-1:0] rsp;
  } host_q_t;

  localparam host_q_t HOST_RST = '{st: H_IDLE, default: '0};

  host_q_t q_q;
  host_q_t q_d;
  logic    wait_a;
  logic    use_wait;

  always_comb begin
    q_d      = q_q;
    q_d.s1   = {pins.wait_pin, pins.ad};
    q_d.s2   = q_q.s1;
    q_d.done = 1'b0;
    wait_a   = pin_act(q_q.s2[DATA_W], pol_wait);
    use_wait = wait_en & direct_mode & q_q.wr;
    case (q_q.st)
      H_IDLE: begin
        if (q_q.gap) begin
          q_d.cnt = q_q.cnt - 4'h1;
          if (q_q.cnt == 4'h0) begin
            q_d.gap  = 1'b0;
            q_d.busy = 1'b0;
          end
        end else if (cmd_valid) begin
          q_d.busy  = 1'b1;
          q_d.wr    = cmd_write;
          q_d.wide  = cmd_wide;
          q_d.addr  = cmd_addr;
          q_d.data  = cmd_data;
          q_d.cs    = 1'b1;
          q_d.ll    = 1'b1;
          q_d.ad    = cmd_addr[DATA_W-1:0];
          q_d.ad_oe = 1'b1;
          q_d.cnt   = LATCH_LOAD;
          q_d.st    = H_LO;
        end
      end
      H_LO: begin
        q_d.cnt = q_q.cnt - 4'h1;
        if (q_q.cnt == LATCH_DROP) begin
          q_d.ll = 1'b0;
        end
        if (q_q.cnt == 4'h0) begin
          q_d.lh  = 1'b1;
          q_d.ad  = q_q.addr[31:DATA_W];
          q_d.cnt = LATCH_LOAD;
          q_d.st  = H_HI;
        end
      end
      H_HI: begin
        q_d.cnt = q_q.cnt - 4'h1;
        if (q_q.cnt == LATCH_DROP) begin
          q_d.lh = 1'b0;
        end
        if (q_q.cnt == 4'h0) begin
          q_d.wre   = q_q.wr | dir_strobe_mode;
          q_d.rdd   = ~q_q.wr;
          q_d.ad    = q_q.data;
          q_d.ad_oe = q_q.wr;
          q_d.be    = q_q.wide ? BE_WIDE : 2'h1;
          q_d.seen  = 1'b0;
          // Without the handshake the strobe stands for the worst-case completion time.
          q_d.cnt   = !q_q.wr ? RD_HOLD : (q_q.wide ? WR16_HOLD : WR8_HOLD);  // [RULE3]
          q_d.st    = H_STRB;
        end
      end
      H_STRB: begin
        q_d.cnt = q_q.cnt - 4'h1;
        if (wait_a) begin
          q_d.seen = 1'b1;
        end
        // The wait line starts inactive, so only a fall after a seen rise ends the cycle.
        if (use_wait ? (q_q.seen && !wait_a) : (q_q.cnt == 4'h0)) begin  // [RULE2]
          q_d.rsp   = q_q.wr ? q_q.rsp : q_q.s2[DATA_W-1:0];
          // Select is dropped together with the strobe, never while it stands.
          q_d.cs    = 1'b0;  // [RULE7]
          q_d.wre   = 1'b0;
          q_d.rdd   = 1'b0;
          q_d.ad_oe = 1'b0;
          q_d.done  = 1'b1;
          q_d.gap   = 1'b1;
          q_d.cnt   = GAP_LOAD;
          q_d.st    = H_IDLE;
        end
      end
      default: begin
        q_d.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q_q <= HOST_RST;
    end else if (ce) begin
      q_q <= q_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pins.cs              = pin_act(q_q.cs, pol_cs) ^ 1'b0;
  assign pins.rd_dir          = pin_act(q_q.rdd, pol_rd_dir);
  assign pins.wr_en           = pin_act(q_q.wre, pol_wr_en);
  assign pins.addr_latch_low  = q_q.ll;
  assign pins.addr_latch_high = q_q.lh;
  assign pins.be              = q_q.be;
  assign pins.host_ad         = q_q.ad;
  assign pins.host_ad_oe      = q_q.ad_oe;
  assign busy                 = q_q.busy;
  assign done                 = q_q.done;
  assign rsp_data             = q_q.rsp;

endmodule // host_port_host
`default_nettype wire

// ==== tb/host_port_sva.sv ====
// Pin-level checker for the parallel host port between host and device ends.
`timescale 1ns/1ps
`default_nettype none
module host_port_sva (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // Configuration
  input wire logic       pol_wait,
  input wire logic       pol_cs,
  input wire logic       pol_rd_dir,
  input wire logic       pol_wr_en,
  input wire logic       dir_strobe_mode,
  input wire logic       direct_mode,
  input wire logic       wait_en,
  // Pins
  input wire logic       cs,
  input wire logic       rd_dir,
  input wire logic       wr_en,
  input wire logic       addr_latch_low,
  input wire logic       addr_latch_high,
  input wire logic [1:0] be,
  input wire logic       dev_ad_oe,
  input wire logic       wait_lvl,
  input wire logic       wait_oe
);
  import host_port_pkg::*;

  // ----------------------------------------
  // Decoded pin meanings
  // ----------------------------------------
  logic       cs_a, sb_a, wr_a, rd_a, wt_a;
  logic [4:0] cnt_q, cnt_d;
  assign cs_a = pin_act(cs, pol_cs);
  assign sb_a = pin_act(wr_en, pol_wr_en) | (~dir_strobe_mode & pin_act(rd_dir, pol_rd_dir));
  assign wr_a = cs_a & pin_act(wr_en, pol_wr_en) & ~(dir_strobe_mode & pin_act(rd_dir, pol_rd_dir));
  assign rd_a = cs_a & pin_act(rd_dir, pol_rd_dir) & (~dir_strobe_mode | pin_act(wr_en, pol_wr_en));
  // Wait counts only while driven, since an undriven line is pulled to a fixed level.
  assign wt_a = wait_oe & pin_act(wait_lvl, pol_wait);
  // Saturating count of write strobe cycles, so a long hold never wraps to a short one.
  always_comb cnt_d = wr_a ? (cnt_q == 5'h1f ? cnt_q : cnt_q + 5'h01) : 5'h00;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) cnt_q <= 5'h00;
    else cnt_q <= cnt_d;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  wait_idle_a: assert property (
    wt_a |-> wr_a)
    else $error("wait active outside a selected write");
  wait_rise_a: assert property (
    $rose(wr_a) && direct_mode && wait_en |-> ##[1:4] wt_a)
    else $error("wait did not go active on write strobe");
  done_byte_a: assert property (
    $rose(wr_a) && direct_mode && wait_en && be == 2'h1 |-> ##[1:10] $fell(wt_a))
    else $error("8-bit write not completed in time");
  done_word_a: assert property (
    $rose(wr_a) && direct_mode && wait_en && be == 2'h3 |-> ##[1:14] $fell(wt_a))
    else $error("16-bit write not completed in time");
  strobe_hold_a: assert property (
    $fell(wr_a) && direct_mode && wait_en |-> !$past(wt_a))
    else $error("write strobe released while wait active");
  fixed_hold_a: assert property (
    $fell(wr_a) && direct_mode && !wait_en
      |-> int'(cnt_q) >= ($past(be) == 2'h3 ? WR16_HOLD_CYC : WR8_HOLD_CYC))
    else $error("write strobe shorter than completion time");
  legacy_wait_a: assert property (
    !direct_mode && wait_oe |-> !wt_a)
    else $error("wait active in legacy mode");
  sel_stable_a: assert property (
    sb_a && $past(sb_a) |-> $stable(cs))
    else $error("select changed under an active strobe");
  latch_sel_a: assert property (
    addr_latch_low || addr_latch_high |-> cs_a)
    else $error("address latch without select");
  read_drive_a: assert property (
    $rose(rd_a) |-> ##[1:5] dev_ad_oe)
    else $error("device did not drive read data");

  cover property ($fell(wt_a));
  cover property ($rose(rd_a) && dir_strobe_mode);
  cover property ($fell(wr_a) && !direct_mode);
endmodule // host_port_sva
`default_nettype wire

// ==== tb/host_port_bus_cycle_tb.sv ====
// Self-checking bench joining host and device ends of the parallel host port.
`timescale 1ns/1ps
`default_nettype none
module host_bus_cycle_handshake_tb;
  import host_port_pkg::*;

  // ----------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------
  typedef struct packed {logic w; logic wide; logic [31:0] a; logic [15:0] d;} exp_t;
  logic        mclk, reset_n, cmd_valid, cmd_write, cmd_wide, seen;
  logic        pol_wait, pol_cs, pol_rd_dir, pol_wr_en;
  logic        dir_strobe_mode, direct_mode, wait_en;
  logic        h_busy, d_busy, done, wr_stb, rd_stb;
  logic [31:0] cmd_addr, acc_addr;
  logic [15:0] cmd_data, rsp_data, wr_data, rd_data, mk;
  logic [1:0]  wr_be;
  int          n_fail, n_checks;
  exp_t        m;
  exp_t        exp_q[$];

  host_port_if u_host_port_if ();
  host_port_host u_host_port_host (
    .mclk(mclk), .reset_n(reset_n), .ce(1'b1),
    .pol_wait(pol_wait), .pol_cs(pol_cs), .pol_rd_dir(pol_rd_dir), .pol_wr_en(pol_wr_en),
    .dir_strobe_mode(dir_strobe_mode), .direct_mode(direct_mode), .wait_en(wait_en),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_wide(cmd_wide),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .busy(h_busy), .done(done),
    .rsp_data(rsp_data), .pins(u_host_port_if.host));
  host_port_device u_host_port_device (
    .mclk(mclk), .reset_n(reset_n), .ce(1'b1),
    .pol_wait(pol_wait), .pol_cs(pol_cs), .pol_rd_dir(pol_rd_dir), .pol_wr_en(pol_wr_en),
    .dir_strobe_mode(dir_strobe_mode), .direct_mode(direct_mode), .wait_en(wait_en),
    .pins(u_host_port_if.device), .wr_stb(wr_stb), .rd_stb(rd_stb), .acc_addr(acc_addr),
    .wr_data(wr_data), .wr_be(wr_be), .rd_data(rd_data), .busy(d_busy));
  host_port_sva u_host_port_sva (
    .mclk(mclk), .reset_n(reset_n),
    .pol_wait(pol_wait), .pol_cs(pol_cs), .pol_rd_dir(pol_rd_dir), .pol_wr_en(pol_wr_en),
    .dir_strobe_mode(dir_strobe_mode), .direct_mode(direct_mode), .wait_en(wait_en),
    .cs(u_host_port_if.cs), .rd_dir(u_host_port_if.rd_dir), .wr_en(u_host_port_if.wr_en),
    .addr_latch_low(u_host_port_if.addr_latch_low),
    .addr_latch_high(u_host_port_if.addr_latch_high), .be(u_host_port_if.be),
    .dev_ad_oe(u_host_port_if.dev_ad_oe), .wait_lvl(u_host_port_if.wait_lvl),
    .wait_oe(u_host_port_if.wait_oe));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic run_cmd(input logic w, input logic wide);
    exp_t e;
    e = {w, wide, 32'($urandom), 16'($urandom)};
    rd_data <= e.d;
    cmd_write <= w;
    cmd_wide <= wide;
    cmd_addr <= e.a;
    cmd_data <= e.d;
    cmd_valid <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    cmd_valid <= 1'b0;
    for (int i = 0; i < 80 && done !== 1'b1; i++) begin
      @(posedge mclk);
    end
    check(32'(done), 32'h1, "command done");
    repeat (2) @(posedge mclk);
  endtask

  // ----------------------------------------
  // Clock, stimulus, monitor, watchdog
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    {cmd_valid, cmd_write, cmd_wide, cmd_addr, cmd_data, rd_data, seen} = '0;
    {pol_wait, pol_cs, pol_rd_dir, pol_wr_en, dir_strobe_mode, direct_mode, wait_en} = '0;
    n_fail = 0;
    n_checks = 0;
    reset_n = 1'b0;
    void'($urandom(11));
    repeat (20) @(posedge mclk);
    // Configuration changes only under reset: a polarity flip on live pins looks like a strobe.
    for (int k = 0; k < 16; k++) begin
      reset_n <= 1'b0;
      {pol_wait, pol_cs, pol_rd_dir, pol_wr_en} <= 4'($urandom);
      {dir_strobe_mode, direct_mode, wait_en} <= 3'(k);
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      for (int j = 0; j < 6; j++) begin
        run_cmd(j < 2 || j == 4 || (j == 5 && $urandom_range(1) == 1), 1'(j));
      end
    end
    check(32'(exp_q.size()), 32'h0, "results left");
    complete_run();
  end

  always @(posedge mclk) begin
    if (exp_q.size() > 0) begin
      m = exp_q[0];
      mk = m.wide ? 16'hffff : 16'h00ff;
      if (wr_stb === 1'b1 || rd_stb === 1'b1) begin
        seen = 1'b1;
        check(32'(d_busy), 32'h1, "device busy");
        check(32'(wr_stb), 32'(m.w), "cycle kind");
        check(acc_addr, m.a, "address");
      end
      if (wr_stb === 1'b1) begin
        check(32'(wr_be), m.wide ? 32'h3 : 32'h1, "byte enables");
        check(32'(wr_data & mk), 32'(m.d & mk), "write data");
      end
      if (done === 1'b1) begin
        check(32'(seen), 32'h1, "device cycle");
        check(32'(h_busy), 32'h1, "host busy");
        if (m.w === 1'b0) begin
          check(32'(rsp_data & mk), 32'(m.d & mk), "read data");
        end
        seen = 1'b0;
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    complete_run();
  end
endmodule // host_bus_cycle_handshake_tb
`default_nettype wire
